// File: seq_regs_pkg.sv
// constants for the last sequencer step and spare register bank
// What this block does
// - bit 15 set includes the last step in the sequence; clear skips it.
// - bits 14:13 set gain: 00 gain 1, 01 gain 2, 10/11 gain 4.
// - bit 4 selects negative input: 0 analog ground, 1 analog input seven.
// - bits 3:0 codes 0 to 7 route external analog input n positive.
// - codes 8 to 12 select temperature, short, test DAC, supply divider taps; 14 and 15 select pin 103.
// - internal positive sources force negative input; the select bit is ignored.
// - first spare bits 11:10 and 5:4 are plain storage, no function.
// - first spare resets 0210h; bits 9:6 read 1000, others zero.
// - second spare is sixteen read/write bits, reset 0000h, no effect.
// - last step register sits at 9Fh, reset 000Fh.
package seq_regs_pkg;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam logic [AW-1:0] ADDR_LAST_STEP  = 8'h9F;
    localparam logic [AW-1:0] ADDR_SPARE_ONE  = 8'hA0;
    localparam logic [AW-1:0] ADDR_SPARE_TWO  = 8'hA1;
    localparam logic [DW-1:0] RST_LAST_STEP   = 16'h000F;
    localparam logic [DW-1:0] RST_SPARE_ONE   = 16'h0210;
    localparam logic [DW-1:0] RST_SPARE_TWO   = 16'h0000;
    localparam logic [DW-1:0] MASK_LAST_STEP  = 16'hE01F;
    localparam logic [DW-1:0] MASK_SPARE_ONE  = 16'h0C30;
    localparam logic [DW-1:0] FIXED_SPARE_ONE = 16'h0200;
    // decoded one-hot for the reset positive code, kept in step with 000Fh
    localparam logic [15:0]   RST_POS_ONEHOT  = 16'h8000;
    localparam logic [15:0]   ONEHOT_BASE     = 16'h0001;
    localparam int EN_BIT   = 15;
    localparam int GAIN_HI  = 14;
    localparam int GAIN_LO  = 13;
    localparam int NEG_BIT  = 4;
    localparam int POS_HI   = 3;
    localparam logic [3:0] POS_TEMP      = 4'h8;
    localparam logic [3:0] POS_SHORT     = 4'h9;
    localparam logic [3:0] POS_TEST_DAC  = 4'hA;
    localparam logic [3:0] POS_ASUP_DIV4 = 4'hB;
    localparam logic [3:0] POS_DSUP_DIV2 = 4'hC;
    localparam logic [3:0] POS_APIN_103  = 4'hE;
    localparam logic [3:0] POS_DPIN_103  = 4'hF;
    localparam logic [2:0] GAIN_ONE  = 3'h1;
    localparam logic [2:0] GAIN_TWO  = 3'h2;
    localparam logic [2:0] GAIN_FOUR = 3'h4;
endpackage

// File: step_cfg_if.sv
// carries the raw last-step fields from the register bank to the decoder
interface step_cfg_if;
    logic [1:0] last_step_gain;
    logic       last_step_neg_input_sel;
    logic [3:0] last_step_pos_input_sel;
    modport src (output last_step_gain, last_step_neg_input_sel,
                 last_step_pos_input_sel);
    modport dst (input last_step_gain, last_step_neg_input_sel,
                 last_step_pos_input_sel);
endinterface

// File: step_mux_decode.sv
// decodes last-step fields into one-hot mux controls and gain
module step_mux_decode
    import seq_regs_pkg::*;
(
    step_cfg_if.dst    cfg,
    output logic [2:0] gain_mult,
    output logic [15:0] pos_onehot,
    output logic       neg_input_seven,
    output logic       neg_internal
);
    always_comb begin
        case (cfg.last_step_gain)
            2'h0:    gain_mult = GAIN_ONE;
            2'h1:    gain_mult = GAIN_TWO;
            default: gain_mult = GAIN_FOUR;
        endcase
        // code values 11/12 hold the divide-by-4 and divide-by-2 taps
        pos_onehot = ONEHOT_BASE << cfg.last_step_pos_input_sel;
        neg_internal = cfg.last_step_pos_input_sel[POS_HI];
        neg_input_seven = cfg.last_step_neg_input_sel & ~neg_internal;
    end
endmodule

// File: seq_step_cfg_and_spare_regs.sv
// register bank for the last sequencer step and two spare registers
module seq_step_cfg_and_spare_regs
    import seq_regs_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [seq_regs_pkg::AW-1:0] addr,
    input  wire logic [seq_regs_pkg::DW-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [seq_regs_pkg::DW-1:0] rdata,
    output logic                            last_step_enable,
    output logic      [2:0]                 last_step_gain_mult,
    output logic      [15:0]                pos_input_onehot,
    output logic                            neg_input_seven,
    output logic                            neg_input_internal
);
    logic [DW-1:0] step_cfg, next_step_cfg;
    logic [DW-1:0] spare_one, next_spare_one;
    logic [DW-1:0] spare_two, next_spare_two;
    logic [DW-1:0] next_rdata;
    logic [2:0]    dec_gain;
    logic [15:0]   dec_pos;
    logic          dec_neg7, dec_negi;

    step_cfg_if cfg_bus ();

    assign cfg_bus.last_step_gain          = step_cfg[GAIN_HI:GAIN_LO];
    assign cfg_bus.last_step_neg_input_sel = step_cfg[NEG_BIT];
    assign cfg_bus.last_step_pos_input_sel = step_cfg[POS_HI:0];

    step_mux_decode u_dec (
        .cfg             (cfg_bus),
        .gain_mult       (dec_gain),
        .pos_onehot      (dec_pos),
        .neg_input_seven (dec_neg7),
        .neg_internal    (dec_negi)
    );

    always_comb begin
        next_step_cfg  = step_cfg;
        next_spare_one = spare_one;
        next_spare_two = spare_two;
        next_rdata     = '0;
        if (wr) begin
            case (addr)
                ADDR_LAST_STEP: next_step_cfg = wdata & MASK_LAST_STEP;
                ADDR_SPARE_ONE: next_spare_one = wdata & MASK_SPARE_ONE;
                ADDR_SPARE_TWO: next_spare_two = wdata;
                default: ;
            endcase
        end
        // unmapped reads return zero; reads have no side effect
        if (rd) begin
            case (addr)
                ADDR_LAST_STEP: next_rdata = step_cfg;
                ADDR_SPARE_ONE: next_rdata = spare_one | FIXED_SPARE_ONE;
                ADDR_SPARE_TWO: next_rdata = spare_two;
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            step_cfg           <= RST_LAST_STEP;
            spare_one          <= RST_SPARE_ONE & MASK_SPARE_ONE;
            spare_two          <= RST_SPARE_TWO;
            rdata              <= '0;
            last_step_enable   <= 1'b0;
            last_step_gain_mult <= GAIN_ONE;
            pos_input_onehot   <= RST_POS_ONEHOT;
            neg_input_seven    <= 1'b0;
            neg_input_internal <= 1'b1;
        end else begin
            step_cfg           <= next_step_cfg;
            spare_one          <= next_spare_one;
            spare_two          <= next_spare_two;
            rdata              <= next_rdata;
            // mux outputs lag the register by one cycle to stay registered
            last_step_enable   <= step_cfg[EN_BIT];
            last_step_gain_mult <= dec_gain;
            pos_input_onehot   <= dec_pos;
            neg_input_seven    <= dec_neg7;
            neg_input_internal <= dec_negi;
        end
    end
endmodule

// File: seq_regs_chk_asserts.sv
// port-level checks on the step and spare register bank
module seq_regs_chk (
    input wire logic        clk, rst_b, wr, rd, last_step_enable,
    input wire logic        neg_input_seven, neg_input_internal,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata, rdata, pos_input_onehot,
    input wire logic [2:0]  last_step_gain_mult
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire w9 = wr && addr == 8'h9F;
    property p_en; w9 |-> ##2 last_step_enable == $past(wdata[15], 2);
    endproperty a_en: assert property (p_en) else $error("en");
    property p_gn; w9 && wdata[14:13] == 2'h3 |-> ##2 last_step_gain_mult == 3'h4;
    endproperty a_gn: assert property (p_gn) else $error("gain");
    property p_oh;
        w9 |-> ##2 pos_input_onehot == 16'h0001 << $past(wdata[3:0], 2);
    endproperty a_oh: assert property (p_oh) else $error("pos");
    property p_ni; w9 |-> ##2 neg_input_internal == $past(wdata[3], 2);
    endproperty a_ni: assert property (p_ni) else $error("int");
    property p_n7; neg_input_seven |-> !neg_input_internal;
    endproperty a_n7: assert property (p_n7) else $error("neg");
    property p_9f; rd && addr == 8'h9F |=> rdata[12:5] == 8'h00;
    endproperty a_9f: assert property (p_9f) else $error("9f");
    property p_a0; rd && addr == 8'hA0 |=> (rdata & 16'hF3CF) == 16'h0200;
    endproperty a_a0: assert property (p_a0) else $error("a0");
    property p_a1; wr && addr == 8'hA1 ##1 rd && addr == 8'hA1
        |=> rdata == $past(wdata, 2);
    endproperty a_a1: assert property (p_a1) else $error("a1");
endmodule
bind seq_step_cfg_and_spare_regs seq_regs_chk u_seq_regs_chk (.*);

// File: tb.sv
// random and corner-case bench for the step and spare register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, en, n7, ni;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, oh, v;
    logic [2:0] gm;
    int err_count = 0, n_compared = 0, seed = 32'hefb1, i;
    always #50 clk = ~clk;
    seq_step_cfg_and_spare_regs u_seq_step_cfg_and_spare_regs (.clk, .rst_b,
        .addr, .wdata, .wr, .rd, .rdata, .last_step_enable(en),
        .last_step_gain_mult(gm), .pos_input_onehot(oh),
        .neg_input_seven(n7), .neg_input_internal(ni));
    task chk(string n, logic [15:0] e, s);
        n_compared++;
        if (e !== s) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task bus(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
    endtask
    task idle;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
    endtask
    // read data stand one cycle only, so look mid-cycle
    task rdc(logic [7:0] a, logic [15:0] e);
        bus(0, a, 16'h0000);
        idle;
        @(negedge clk) chk("rdata", e, rdata);
        // read data must fall back to zero once the answer cycle is over
        @(negedge clk) chk("rdata_idle", 16'h0000, rdata);
    endtask
    function logic [15:0] ctl(logic [15:0] d);
        return {10'h0, d[15], d[14] ? 3'h4 : (d[13] ? 3'h2 : 3'h1),
                d[4] & !d[3], d[3]};
    endfunction
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        give_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        @(negedge clk);
        chk("onehot", 16'h8000, oh);
        chk("ctl", {10'h0, 1'b0, 3'h1, 1'b0, 1'b1}, {10'h0, en, gm, n7, ni});
        rdc(8'h9F, 16'h000F);
        rdc(8'hA0, 16'h0210);
        rdc(8'hA1, 16'h0000);
        for (i = 0; i < 40; i++) begin
            v = $random(seed);
            if (i < 16) begin
                v[3:0] = i[3:0];
                v[14:13] = i[1:0];
            end
            bus(1, 8'h9F, v);
            idle;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("onehot", 16'h0001 << v[3:0], oh);
            chk("ctl", ctl(v), {10'h0, en, gm, n7, ni});
            rdc(8'h9F, v & 16'hE01F);
            bus(1, 8'hA0, v);
            rdc(8'hA0, v & 16'h0C30 | 16'h0200);
            bus(1, 8'hA1, ~v);
            rdc(8'hA1, ~v);
            rdc(8'hA2 + 8'(i), 16'h0000);
            $display("pass %0d done", i);
        end
        give_verdict;
    end
endmodule
